// ---- src/diaf_framer.v ----
`timescale 1ns/1ns
`default_nettype none
`include "diaf_defs.vh"

module diaf_framer #(
    parameter N_OBJ = 16,
    parameter N_SUB = 2,
    parameter [2*N_OBJ-1:0] OBJ_TYPES = 32'h5555_5555
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire fault_flag,
    input wire warn_flag,
    input wire fwd_running,
    input wire rev_running,
    input wire ready,
    input wire ctrl_source_net,
    input wire ref_source_net,
    input wire at_ref_flag,
    input wire [2:0] drive_state,
    input wire [15:0] speed_actual,
    input wire [15:0] torque_actual,
    input wire [N_OBJ*N_SUB*32-1:0] obj_data,
    input wire tx_start,
    output reg [7:0] byte_data,
    output reg byte_valid,
    output reg byte_last,
    input wire byte_ready,
    output reg frame_busy
);
    localparam ST_IDLE = 2'd0;
    localparam ST_HDR = 2'd1;
    localparam ST_ITEM = 2'd2;

    reg [7:0] inst_q;
    reg [15:0] hdr_fmt_q;
    reg [15:0] sel_q [0:`DIAF_N_ITEMS-1];
    reg [15:0] sub_q [0:`DIAF_N_SUBSET-1];
    reg [7:0] awaddr_q;
    reg aw_have_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg w_have_q;
    reg [1:0] state_q;
    reg [15:0] fmt_q;
    reg [2:0] hlen_q;
    reg [2:0] hpos_q;
    reg [3:0] item_q;
    reg [1:0] ipos_q;
    reg [6:0] rem_q;
    reg [31:0] cur_q;
    reg [2:0] len_q [0:`DIAF_N_ITEMS-1];
    reg [7:0] snap_flags_q;
    reg [2:0] snap_state_q;
    reg [15:0] snap_speed_q;
    reg [15:0] snap_torque_q;
    wire [2:0] item_len [0:`DIAF_N_ITEMS-1];
    wire [31:0] item_val [0:`DIAF_N_ITEMS-1];
    reg [15:0] act_fmt;
    reg items_on;
    reg [6:0] total;
    reg [31:0] rd_d;
    reg rd_err;
    wire [5:0] aw_word;
    wire wr_fire;
    wire adv;
    // one loop index per process, so no block retriggers another through it
    integer i;
    integer ti;
    integer ri;
    integer fi;

    function [2:0] hdr_len;
        input [15:0] f;
        begin
            case (f)
                {8'h00, `DIAF_INST_BASIC}, {8'h00, `DIAF_INST_EXT}: hdr_len = `DIAF_HLEN_SHORT;
                {8'h00, `DIAF_INST_SPDTRQ}, {8'h00, `DIAF_INST_EXTTRQ}: hdr_len = `DIAF_HLEN_LONG;
                default: hdr_len = 3'h0;
            endcase
        end
    endfunction

    // byte of a fixed layout, taken from the frame's snapshot
    function [7:0] hdr_byte;
        input [15:0] f;
        input [2:0] pos;
        reg ext;
        begin
            ext = (f == {8'h00, `DIAF_INST_EXT}) || (f == {8'h00, `DIAF_INST_EXTTRQ});
            case (pos)
                3'h0: begin
                    if (ext) begin
                        hdr_byte = snap_flags_q;
                    end else begin
                        hdr_byte = {5'b00000, snap_flags_q[`DIAF_B_FWD], 1'b0, snap_flags_q[`DIAF_B_FAULT]};
                    end
                end
                3'h1: hdr_byte = ext ? {5'b00000, snap_state_q} : 8'h00;
                3'h2: hdr_byte = snap_speed_q[7:0];
                3'h3: hdr_byte = snap_speed_q[15:8];
                3'h4: hdr_byte = snap_torque_q[7:0];
                default: hdr_byte = snap_torque_q[15:8];
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < `DIAF_N_ITEMS; g = g + 1) begin : g_item
            wire [7:0] subx;
            if (g < `DIAF_N_SUBITEMS) begin : g_sub
                assign subx = (g % 2 == 0) ? sub_q[g/2][7:0] : sub_q[g/2][15:8];
            end else begin : g_zero
                assign subx = 8'h00;
            end
            diaf_obj_lookup #(
                .N_OBJ(N_OBJ),
                .N_SUB(N_SUB),
                .OBJ_TYPES(OBJ_TYPES)
            ) u_lookup (
                .sel(sel_q[g]),
                .subidx(subx),
                .obj_data(obj_data),
                .len(item_len[g]),
                .val(item_val[g])
            );
        end
    endgenerate

    always @* begin
        ti = 0;
        items_on = (inst_q == `DIAF_INST_CFG);
        act_fmt = items_on ? hdr_fmt_q : {8'h00, inst_q};
        total = {4'h0, hdr_len(act_fmt)};
        if (items_on) begin
            for (ti = 0; ti < `DIAF_N_ITEMS; ti = ti + 1) begin
                total = total + {4'h0, item_len[ti]};
            end
        end
    end

    // register read mux
    always @* begin
        ri = 0;
        rd_d = 32'h0000_0000;
        rd_err = 1'b0;
        case (s_axi_araddr[7:2])
            `DIAF_W_CTRL: rd_d = {24'h00_0000, inst_q};
            `DIAF_W_HDRFMT: rd_d = {16'h0000, hdr_fmt_q};
            `DIAF_W_STATUS: rd_d = {23'h00_0000, frame_busy, 1'b0, total};
            default: begin
                rd_err = 1'b1;
                for (ri = 0; ri < `DIAF_N_ITEMS; ri = ri + 1) begin
                    if (s_axi_araddr[7:2] == `DIAF_W_SEL + ri[5:0]) begin
                        rd_d = {16'h0000, sel_q[ri]};
                        rd_err = 1'b0;
                    end
                end
                for (ri = 0; ri < `DIAF_N_SUBSET; ri = ri + 1) begin
                    if (s_axi_araddr[7:2] == `DIAF_W_SUB + ri[5:0]) begin
                        rd_d = {16'h0000, sub_q[ri]};
                        rd_err = 1'b0;
                    end
                end
            end
        endcase
    end

    assign aw_word = awaddr_q[7:2];
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    // write channels: address and data taken in either order, answer after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DIAF_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            inst_q <= `DIAF_INST_RESET;
            hdr_fmt_q <= `DIAF_SEL_NONE;
            for (i = 0; i < `DIAF_N_ITEMS; i = i + 1) begin
                sel_q[i] <= `DIAF_SEL_NONE;
            end
            for (i = 0; i < `DIAF_N_SUBSET; i = i + 1) begin
                sub_q[i] <= 16'h0000;
            end
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end else if (!aw_have_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end else if (!w_have_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `DIAF_RESP_SLVERR;
                // instance, header format and item lengths are snapshotted at start; item values follow the live selectors mid-frame
                if (aw_word == `DIAF_W_CTRL) begin
                    s_axi_bresp <= `DIAF_RESP_OKAY;
                    if (wstrb_q[0]) inst_q <= wdata_q[7:0];
                end
                if (aw_word == `DIAF_W_HDRFMT) begin
                    s_axi_bresp <= `DIAF_RESP_OKAY;
                    if (wstrb_q[0]) hdr_fmt_q[7:0] <= wdata_q[7:0];
                    if (wstrb_q[1]) hdr_fmt_q[15:8] <= wdata_q[15:8];
                end
                if (aw_word == `DIAF_W_STATUS) begin
                    s_axi_bresp <= `DIAF_RESP_OKAY;
                end
                for (i = 0; i < `DIAF_N_ITEMS; i = i + 1) begin
                    if (aw_word == `DIAF_W_SEL + i[5:0]) begin
                        s_axi_bresp <= `DIAF_RESP_OKAY;
                        if (wstrb_q[0]) sel_q[i][7:0] <= wdata_q[7:0];
                        if (wstrb_q[1]) sel_q[i][15:8] <= wdata_q[15:8];
                    end
                end
                for (i = 0; i < `DIAF_N_SUBSET; i = i + 1) begin
                    if (aw_word == `DIAF_W_SUB + i[5:0]) begin
                        s_axi_bresp <= `DIAF_RESP_OKAY;
                        if (wstrb_q[0]) sub_q[i][7:0] <= wdata_q[7:0];
                        if (wstrb_q[1]) sub_q[i][15:8] <= wdata_q[15:8];
                    end
                end
            end
        end
    end

    // read channel: one read in flight, data one cycle after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DIAF_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_err ? `DIAF_RESP_SLVERR : `DIAF_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    assign adv = !byte_valid || byte_ready;

    // frame engine; a zero-length item costs one idle cycle instead of a priority search
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            frame_busy <= 1'b0;
            byte_data <= 8'h00;
            byte_valid <= 1'b0;
            byte_last <= 1'b0;
            fmt_q <= 16'h0000;
            hlen_q <= 3'h0;
            hpos_q <= 3'h0;
            item_q <= 4'h0;
            ipos_q <= 2'b00;
            rem_q <= 7'h00;
            cur_q <= 32'h0000_0000;
            snap_flags_q <= 8'h00;
            snap_state_q <= 3'h0;
            snap_speed_q <= 16'h0000;
            snap_torque_q <= 16'h0000;
            for (fi = 0; fi < `DIAF_N_ITEMS; fi = fi + 1) begin
                len_q[fi] <= 3'h0;
            end
        end else begin
            if (byte_valid && byte_ready) begin
                byte_valid <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    // an all-empty configuration sends nothing
                    if (tx_start && (total != 7'h00)) begin
                        frame_busy <= 1'b1;
                        fmt_q <= act_fmt;
                        hlen_q <= hdr_len(act_fmt);
                        rem_q <= total;
                        hpos_q <= 3'h0;
                        item_q <= 4'h0;
                        ipos_q <= 2'b00;
                        snap_flags_q <= {at_ref_flag, ref_source_net, ctrl_source_net, ready,
                                         rev_running, fwd_running, warn_flag, fault_flag};
                        snap_state_q <= drive_state;
                        snap_speed_q <= speed_actual;
                        snap_torque_q <= torque_actual;
                        for (fi = 0; fi < `DIAF_N_ITEMS; fi = fi + 1) begin
                            len_q[fi] <= items_on ? item_len[fi] : 3'h0;
                        end
                        state_q <= (hdr_len(act_fmt) != 3'h0) ? ST_HDR : ST_ITEM;
                    end
                end
                ST_HDR: begin
                    if (adv) begin
                        byte_data <= hdr_byte(fmt_q, hpos_q);
                        byte_valid <= 1'b1;
                        byte_last <= (rem_q == 7'h01);
                        rem_q <= rem_q - 7'h01;
                        hpos_q <= hpos_q + 3'h1;
                        if (rem_q == 7'h01) begin
                            state_q <= ST_IDLE;
                            frame_busy <= 1'b0;
                        end else if (hpos_q + 3'h1 == hlen_q) begin
                            state_q <= ST_ITEM;
                        end
                    end
                end
                ST_ITEM: begin
                    if (len_q[item_q] == 3'h0) begin
                        item_q <= item_q + 4'h1;
                    end else if (adv) begin
                        // item word is latched on its first byte so its bytes never tear
                        if (ipos_q == 2'b00) begin
                            byte_data <= item_val[item_q][7:0];
                            cur_q <= item_val[item_q];
                        end else begin
                            byte_data <= cur_q[{ipos_q, 3'b000} +: 8];
                        end
                        byte_valid <= 1'b1;
                        byte_last <= (rem_q == 7'h01);
                        rem_q <= rem_q - 7'h01;
                        if ({1'b0, ipos_q} + 3'h1 == len_q[item_q]) begin
                            ipos_q <= 2'b00;
                            item_q <= item_q + 4'h1;
                        end else begin
                            ipos_q <= ipos_q + 2'b01;
                        end
                        if (rem_q == 7'h01) begin
                            state_q <= ST_IDLE;
                            frame_busy <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    frame_busy <= 1'b0;
                end
            endcase
        end
    end
endmodule // diaf_framer

`default_nettype wire

// ---- src/diaf_defs.vh ----
`ifndef DIAF_DEFS_VH
`define DIAF_DEFS_VH

// producing instance codes
`define DIAF_INST_BASIC 8'h46
`define DIAF_INST_EXT 8'h47
`define DIAF_INST_SPDTRQ 8'h48
`define DIAF_INST_EXTTRQ 8'h49
`define DIAF_INST_CFG 8'h96
`define DIAF_INST_RESET 8'h46

// selector value that removes a portion
`define DIAF_SEL_NONE 16'h270f

// header lengths and absent-item length in bytes
`define DIAF_HLEN_SHORT 3'h4
`define DIAF_HLEN_LONG 3'h6
`define DIAF_LEN_ABSENT 3'h2

// configurable layout shape
`define DIAF_N_ITEMS 14
`define DIAF_N_SUBSET 5
`define DIAF_N_SUBITEMS 10

// byte 0 field positions
`define DIAF_B_FAULT 0
`define DIAF_B_WARN 1
`define DIAF_B_FWD 2
`define DIAF_B_REV 3
`define DIAF_B_READY 4
`define DIAF_B_CTRL 5
`define DIAF_B_REF 6
`define DIAF_B_ATREF 7

// register word indices (byte address = 4 * index) and status busy bit position
`define DIAF_W_CTRL 6'h00
`define DIAF_W_HDRFMT 6'h01
`define DIAF_W_STATUS 6'h02
`define DIAF_W_SEL 6'h04
`define DIAF_W_SUB 6'h14
`define DIAF_STAT_BUSY 8

// axi responses
`define DIAF_RESP_OKAY 2'b00
`define DIAF_RESP_SLVERR 2'b10

`endif

// ---- src/diaf_obj_lookup.v ----
`timescale 1ns/1ns
`default_nettype none
`include "diaf_defs.vh"

module diaf_obj_lookup #(
    parameter N_OBJ = 16,
    parameter N_SUB = 2,
    parameter [2*N_OBJ-1:0] OBJ_TYPES = 32'h5555_5555
) (
    input wire [15:0] sel,
    input wire [7:0] subidx,
    input wire [N_OBJ*N_SUB*32-1:0] obj_data,
    output reg [2:0] len,
    output reg [31:0] val
);
    reg [1:0] code;
    reg [31:0] word;

    always @* begin
        code = 2'b00;
        word = 32'h0000_0000;
        len = 3'h0;
        val = 32'h0000_0000;
        if (sel != `DIAF_SEL_NONE) begin
            if ((sel < N_OBJ) && (subidx < N_SUB)) begin
                // length follows the object's data type code: 1 to 4 bytes
                code = OBJ_TYPES[2*sel +: 2];
                len = {1'b0, code} + 3'h1;
                word = obj_data[32*(sel*N_SUB+subidx) +: 32];
                case (code)
                    2'b00: val = {24'h00_0000, word[7:0]};
                    2'b01: val = {16'h0000, word[15:0]};
                    2'b10: val = {8'h00, word[23:0]};
                    default: val = word;
                endcase
            end else begin
                // absent object keeps a slot but reads zero
                len = `DIAF_LEN_ABSENT;
                val = 32'h0000_0000;
            end
        end
    end
endmodule // diaf_obj_lookup

`default_nettype wire

// ---- tb/diaf_framer_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module diaf_framer_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic [7:0] byte_data,
    input wire logic byte_valid,
    input wire logic byte_last,
    input wire logic byte_ready,
    input wire logic frame_busy
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_STALL_HOLD: assert property (byte_valid && !byte_ready |=>
        byte_valid && $stable(byte_data) && $stable(byte_last)) else $error("byte changed under stall");
    // skipped items may cost an idle cycle each, hence the window
    AST_FIRST_BYTE: assert property ($rose(frame_busy) |-> ##[1:16] byte_valid)
        else $error("no first byte after start");
    AST_LAST_FREES: assert property (byte_valid && byte_last |-> !frame_busy)
        else $error("busy while last byte shown");
    AST_LAST_GAP: assert property (byte_valid && byte_ready && byte_last |=> !byte_valid)
        else $error("byte right after last");
    AST_BYTE_IN_FRAME: assert property (byte_valid |-> frame_busy || byte_last)
        else $error("stray byte outside frame");
    // both halves are parked for one cycle before the answer is raised
    AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 (s_axi_bvalid && !s_axi_awready)) else $error("write not answered");
    AST_W_UNMAPPED: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h64
        |-> ##[1:4] (s_axi_bvalid && s_axi_bresp == 2'b10)) else $error("unmapped write not refused");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    AST_R_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0c
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
endmodule // diaf_framer_props
bind diaf_framer diaf_framer_props u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .byte_data(byte_data),
    .byte_valid(byte_valid), .byte_last(byte_last), .byte_ready(byte_ready), .frame_busy(frame_busy)
);
`default_nettype wire

// ---- tb/diaf_scanner.sv ----
`timescale 1ns/1ns
`default_nettype none
module diaf_scanner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire logic [7:0] byte_data,
    input wire logic byte_valid,
    input wire logic byte_last,
    output logic byte_ready
);
    logic [7:0] rxq[$];
    int last_at = -1;
    logic [1:0] cnt_q = 2'h0;
    initial byte_ready = 1'b0;
    // a slow controller takes one byte in four, so the framer must hold bytes across stalls
    always @(posedge aclk) begin
        cnt_q <= cnt_q + 2'h1;
        byte_ready <= aresetn && (!slow || cnt_q == 2'h3);
        if (byte_valid && byte_ready) begin
            rxq.push_back(byte_data);
            if (byte_last)
                last_at <= rxq.size() - 1;
        end
    end
endmodule // diaf_scanner
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "diaf_defs.vh"
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    wire awready, wready, bvalid, arready, rvalid, byte_valid, byte_last, byte_ready, frame_busy;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] byte_data;
    logic [7:0] st = 8'h00;
    logic [2:0] dstate = 3'h0;
    logic [15:0] spd = 16'h0, trq = 16'h0;
    logic [1023:0] objs;
    logic tx_start = 1'b0, slow = 1'b0;
    int n_errors = 0, total_checks = 0;
    logic [7:0] expq[$];
    logic [31:0] rd;
    logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h44, 8'h50, 8'h60};
    logic [31:0] rv [7] = '{32'h46, 32'h270f, 32'h4, 32'h270f, 32'h270f, 32'h0, 32'h0};
    logic [15:0] sels [14] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h270f, 16'h5, 16'h6, 16'h14, 16'h8,
        16'h9, 16'ha, 16'hb, 16'hc, 16'hd};
    logic [15:0] subs [5] = '{16'h0100, 16'h0001, 16'h0501, 16'h0001, 16'h0100};
    initial forever #20 aclk = ~aclk;
    // objects 0..3 are one to four bytes long, the rest two
    diaf_framer #(.OBJ_TYPES(32'h5555_55e4)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fault_flag(st[0]),
        .warn_flag(st[1]), .fwd_running(st[2]), .rev_running(st[3]), .ready(st[4]),
        .ctrl_source_net(st[5]), .ref_source_net(st[6]), .at_ref_flag(st[7]), .drive_state(dstate),
        .speed_actual(spd), .torque_actual(trq), .obj_data(objs), .tx_start(tx_start),
        .byte_data(byte_data), .byte_valid(byte_valid), .byte_last(byte_last), .byte_ready(byte_ready),
        .frame_busy(frame_busy)
    );
    diaf_scanner u_scn (.aclk(aclk), .aresetn(aresetn), .slow(slow), .byte_data(byte_data),
        .byte_valid(byte_valid), .byte_last(byte_last), .byte_ready(byte_ready));
    function automatic logic [31:0] objw(input int o, input int s);
        return {8'h40 + 8'(o), 8'h30 + 8'(s), 8'h20 + 8'(o), 8'h10 + 8'(s)};
    endfunction
    task automatic print_verdict;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic timed_out;
        n_errors++;
        $display("[ERR] %0t wait ran out", $time);
        print_verdict();
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        if (i == 50)
            timed_out();
        bready <= 1'b0;
        check(32'(bresp), 32'(er));
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        if (i == 50)
            timed_out();
        d = rdata;
        rready <= 1'b0;
        check(32'(rresp), 32'(er));
    endtask
    task automatic push_hdr(input logic [7:0] inst);
        logic ext;
        ext = inst == `DIAF_INST_EXT || inst == `DIAF_INST_EXTTRQ;
        expq.push_back(ext ? st : {5'h0, st[2], 1'b0, st[0]});
        expq.push_back(ext ? {5'h0, dstate} : 8'h00);
        expq.push_back(spd[7:0]);
        expq.push_back(spd[15:8]);
        if (inst == `DIAF_INST_SPDTRQ || inst == `DIAF_INST_EXTTRQ) begin
            expq.push_back(trq[7:0]);
            expq.push_back(trq[15:8]);
        end
    endtask
    task automatic push_item(input logic [15:0] sel, input logic [7:0] sub);
        logic [31:0] w;
        int len;
        if (sel == `DIAF_SEL_NONE)
            return;
        len = 2;
        w = 32'h0;
        if (sel < 16 && sub < 2) begin
            len = sel < 4 ? sel + 1 : 2;
            w = objw(sel, sub);
        end
        for (int b = 0; b < len; b++)
            expq.push_back(w[8*b +: 8]);
    endtask
    task automatic frame;
        int i;
        @(posedge aclk);
        tx_start <= 1'b1;
        @(posedge aclk);
        tx_start <= 1'b0;
        for (i = 0; i < 400; i++) begin
            @(posedge aclk);
            if (byte_valid && byte_ready && byte_last)
                break;
        end
        if (i == 400)
            timed_out();
        @(posedge aclk);
        check(32'(u_scn.rxq.size()), 32'(expq.size()));
        foreach (expq[j])
            check(32'(u_scn.rxq[j]), 32'(expq[j]));
        check(32'(u_scn.last_at), 32'(expq.size() - 1));
        u_scn.rxq.delete();
        expq.delete();
    endtask
    initial begin
        for (int o = 0; o < 32; o++)
            objs[32*o +: 32] = objw(o / 2, o % 2);
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            axi_rd(ra[i], `DIAF_RESP_OKAY, rd);
            check(rd, rv[i]);
        end
        axi_rd(8'h0c, `DIAF_RESP_SLVERR, rd);
        check(rd, 32'h0);
        axi_wr(8'h64, 32'h1, `DIAF_RESP_SLVERR);
        axi_wr(8'h08, 32'hff, `DIAF_RESP_OKAY);
        axi_rd(8'h08, `DIAF_RESP_OKAY, rd);
        check(rd, 32'h4);
        for (int i = 0; i < 8; i++) begin
            st <= 8'ha5 + 8'(i * 37);
            dstate <= 3'(i);
            spd <= 16'h1234 + 16'(i * 257);
            trq <= 16'hbe01 + 16'(i * 3);
            slow <= i[0];
            axi_wr(8'h00, 32'h46 + 32'(i % 4), `DIAF_RESP_OKAY);
            push_hdr(8'h46 + 8'(i % 4));
            frame();
        end
        axi_wr(8'h00, 32'h96, `DIAF_RESP_OKAY);
        for (int k = 0; k < 14; k++)
            axi_wr(8'h10 + 8'(4 * k), 32'(sels[k]), `DIAF_RESP_OKAY);
        for (int j = 0; j < 5; j++)
            axi_wr(8'h50 + 8'(4 * j), 32'(subs[j]), `DIAF_RESP_OKAY);
        for (int r = 0; r < 2; r++) begin
            axi_wr(8'h04, r ? 32'h270f : 32'h49, `DIAF_RESP_OKAY);
            slow <= r[0];
            if (r == 0)
                push_hdr(`DIAF_INST_EXTTRQ);
            for (int k = 0; k < 14; k++)
                push_item(sels[k], k > 9 ? 8'h0 : (k[0] ? subs[k/2][15:8] : subs[k/2][7:0]));
            axi_rd(8'h08, `DIAF_RESP_OKAY, rd);
            check(rd, 32'(expq.size()));
            frame();
        end
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
